/* File: rtl/usfw_pkg.sv */
// usfw_pkg: constants, state codes and carriers of the start frame wake receiver.
// assumes: used by rtl/usfw_start_frame_wake.sv and the bench; rtl/usfw_fifo.sv does not use it.
package usfw_pkg;

  // --------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------
  localparam int DATA_BITS_DEF  = 8;
  localparam int DATA_BITS_MIN  = 5;
  localparam int DATA_BITS_MAX  = 9;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int BAUD_DIV_W     = 12;
  localparam int OS_CNT_W       = 5;

  // --------------------------------------------------------------
  // oversampling reload values (ticks minus one)
  // --------------------------------------------------------------
  localparam logic [OS_CNT_W-1:0] OS_FULL_NORMAL = 5'h0f;
  localparam logic [OS_CNT_W-1:0] OS_HALF_NORMAL = 5'h07;
  localparam logic [OS_CNT_W-1:0] OS_FULL_DOUBLE = 5'h07;
  localparam logic [OS_CNT_W-1:0] OS_HALF_DOUBLE = 5'h03;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h2,
    ST_STOP  = 3'h3,
    ST_HOLD  = 3'h4
  } usfw_state_t;

  typedef struct packed {
    logic sfd_en;
    logic start_irq_en;
    logic sync_mode;
    logic double_speed;
  } usfw_ctrl_t;

endpackage

/* File: rtl/usfw_fifo.sv */
// usfw_fifo: synchronous fifo, valid/ready on both sides, registered output stage.
// assumes: one clock, reset already synchronised by the instantiating module.
`timescale 1ns/1ps
`default_nettype none
module usfw_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("usfw_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      cnt;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_cnt;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             push;
  logic             load;

  // output stage adds one word beyond DEPTH; in_ready tracks the array only
  assign in_ready_o = (cnt != (AW+1)'(DEPTH));
  assign push       = in_valid_i && in_ready_o;
  assign load       = (cnt != '0) && (!out_valid_o || out_ready_i);

  always_comb begin
    next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = load ? rd_ptr + 1'b1 : rd_ptr;
    next_cnt       = cnt + (AW+1)'(push) - (AW+1)'(load);
    next_out_data  = load ? mem[rd_ptr] : out_data_o;
    next_out_valid = load ? 1'b1 : (out_valid_o && !out_ready_i);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      cnt         <= '0;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else begin
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      cnt         <= next_cnt;
      out_valid_o <= next_out_valid;
      out_data_o  <= next_out_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/usfw_start_frame_wake.sv */
// usfw_start_frame_wake: serial receiver with start frame detection that wakes the device.
// assumes: CORE_CLK_I is the always-on 125 MHz sampling clock; the oscillator and the
// clock gates it steers live outside; the core raises SLEEP_REQ_I to enter sleep.
//
// Functional notes
// R1: a start bit seen on the receive line wakes the device out of any sleep mode.
// R2: a falling receive line powers up the 8 MHz oscillator and enables the serial clock.
// R3: the far transmitter keeps its baud rate low enough for the oscillator start-up.
// R4: start detection works in asynchronous and in synchronous framing alike.
// R5: with start_frame_detect_enable clear, no start edge wakes the device.
// R6: with rx_start_irq_enable set, the start interrupt fires at once on the start bit.
// R7: without it, only oscillator and serial clock run until receive complete wakes the core.
// R8: synchronous bit rate from idle sleep stays at or below system clock over four.
// R9: synchronous bit rate from standby or power-down stays at or below 500 kbps.
// R10: asynchronous rate from idle sleep may equal the active-mode rate.
// R11: normal speed baud error stays in limits, 8-bit up to 28.8 kbps +4.58/-4.00 percent.
// R12: double speed baud error stays in limits, 8-bit up to 57.6 kbps +3.90/-2.70 percent.
// R13: the falling-edge detector needs no oscillator to catch a start edge.
`timescale 1ns/1ps
`default_nettype none
module usfw_start_frame_wake #(
  parameter int DATA_BITS  = usfw_pkg::DATA_BITS_DEF,
  parameter int FIFO_DEPTH = usfw_pkg::FIFO_DEPTH_DEF
) (
  // clock and reset
  input  wire logic                             CORE_CLK_I,
  input  wire logic                             RST_N_I,
  // serial pins
  input  wire logic                             SERIAL_RX_LINE_I,
  input  wire logic                             SERIAL_XCK_I,
  // control from the core
  input  wire logic                             START_FRAME_DETECT_ENABLE_I,
  input  wire logic                             RX_START_IRQ_ENABLE_I,
  input  wire logic                             SYNC_MODE_I,
  input  wire logic                             DOUBLE_SPEED_I,
  input  wire logic [usfw_pkg::BAUD_DIV_W-1:0]  BAUD_DIV_I,
  input  wire logic                             SLEEP_REQ_I,
  // clock control
  output logic                                  OSC_ENABLE_O,
  output logic                                  SERIAL_CLK_ENABLE_O,
  output logic                                  SYS_CLK_ENABLE_O,
  // events
  output logic                                  RX_START_IRQ_O,
  output logic                                  RX_COMPLETE_IRQ_O,
  // received words
  output logic                                  RX_VALID_O,
  input  wire logic                             RX_READY_I,
  output logic      [DATA_BITS-1:0]             RX_DATA_O,
  output logic                                  RX_FRAME_ERR_O
);
  if (DATA_BITS < usfw_pkg::DATA_BITS_MIN || DATA_BITS > usfw_pkg::DATA_BITS_MAX) begin : g_bad_bits
    $error("usfw_start_frame_wake: DATA_BITS out of range");
  end

  localparam logic [3:0] LAST_BIT = 4'(DATA_BITS - 1);

  // --------------------------------------------------------------
  // reset release and pin synchronisers
  // --------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;
  logic rx_s1;
  logic rx_s2;
  logic rx_prev;
  logic xck_s1;
  logic xck_s2;
  logic xck_prev;

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // idle line is high; reset to that so release gives no false edge
  always_ff @(posedge CORE_CLK_I or negedge rst_sync) begin
    if (!rst_sync) begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_prev  <= 1'b1;
      xck_s1   <= 1'b0;
      xck_s2   <= 1'b0;
      xck_prev <= 1'b0;
    end else begin
      rx_s1    <= SERIAL_RX_LINE_I;
      rx_s2    <= rx_s1;
      rx_prev  <= rx_s2;
      xck_s1   <= SERIAL_XCK_I;
      xck_s2   <= xck_s1;
      xck_prev <= xck_s2;
    end
  end

  usfw_pkg::usfw_ctrl_t ctrl;
  logic                 fall;
  logic                 xck_rise;

  assign ctrl     = '{sfd_en:       START_FRAME_DETECT_ENABLE_I,
                      start_irq_en: RX_START_IRQ_ENABLE_I,
                      sync_mode:    SYNC_MODE_I,
                      double_speed: DOUBLE_SPEED_I};
  // edge found from the always-on sampler, never from the gated oscillator
  assign fall     = rx_prev && !rx_s2; // R13
  assign xck_rise = xck_s2 && !xck_prev;

  // --------------------------------------------------------------
  // receiver and wake control
  // --------------------------------------------------------------
  usfw_pkg::usfw_state_t                state;
  usfw_pkg::usfw_state_t                next_state;
  logic [usfw_pkg::BAUD_DIV_W-1:0]      div_cnt;
  logic [usfw_pkg::BAUD_DIV_W-1:0]      next_div_cnt;
  logic [usfw_pkg::OS_CNT_W-1:0]        os_cnt;
  logic [usfw_pkg::OS_CNT_W-1:0]        next_os_cnt;
  logic [3:0]                           bit_cnt;
  logic [3:0]                           next_bit_cnt;
  logic [DATA_BITS-1:0]                 shift;
  logic [DATA_BITS-1:0]                 next_shift;
  logic                                 ferr;
  logic                                 next_ferr;
  logic                                 session;
  logic                                 next_session;
  logic                                 awake;
  logic                                 next_awake;
  logic                                 next_osc;
  logic                                 next_start_irq;
  logic                                 start_det;
  logic                                 complete;
  logic                                 push;
  logic                                 fifo_in_ready;
  logic                                 tick;
  logic                                 samp;
  logic [usfw_pkg::OS_CNT_W-1:0]        os_full;
  logic [usfw_pkg::OS_CNT_W-1:0]        os_half;

  assign tick    = (div_cnt == '0);
  assign os_full = ctrl.double_speed ? usfw_pkg::OS_FULL_DOUBLE : usfw_pkg::OS_FULL_NORMAL;
  assign os_half = ctrl.double_speed ? usfw_pkg::OS_HALF_DOUBLE : usfw_pkg::OS_HALF_NORMAL;
  // synchronous framing samples on the partner clock, asynchronous on mid-bit ticks
  assign samp    = ctrl.sync_mode ? xck_rise : (tick && os_cnt == '0); // R4

  always_comb begin
    next_state     = state;
    next_div_cnt   = tick ? BAUD_DIV_I : div_cnt - 1'b1;
    next_os_cnt    = (tick && os_cnt != '0) ? os_cnt - 1'b1 : os_cnt;
    next_bit_cnt   = bit_cnt;
    next_shift     = shift;
    next_ferr      = ferr;
    next_session   = session;
    start_det      = 1'b0;
    complete       = 1'b0;
    push           = 1'b0;
    case (state)
      usfw_pkg::ST_IDLE: begin
        // asleep with detection off: the line is ignored entirely
        if (fall && (awake || ctrl.sfd_en)) begin // R5
          next_state   = usfw_pkg::ST_START;
          next_div_cnt = BAUD_DIV_I;
          next_os_cnt  = os_half;
          start_det    = 1'b1;
          next_session = !awake; // R1
        end
      end
      usfw_pkg::ST_START: begin
        if (samp) begin
          if (!rx_s2) begin
            next_state   = usfw_pkg::ST_DATA;
            next_bit_cnt = 4'h0;
            next_os_cnt  = os_full;
          end else begin
            // glitch, not a start bit: drop the session and sleep on
            next_state   = usfw_pkg::ST_IDLE;
            next_session = 1'b0;
          end
        end
      end
      usfw_pkg::ST_DATA: begin
        if (samp) begin
          next_shift  = {rx_s2, shift[DATA_BITS-1:1]};
          next_os_cnt = os_full;
          if (bit_cnt == LAST_BIT) begin
            next_state = usfw_pkg::ST_STOP;
          end else begin
            next_bit_cnt = bit_cnt + 4'h1;
          end
        end
      end
      usfw_pkg::ST_STOP: begin
        if (samp) begin
          next_ferr  = !rx_s2;
          next_state = usfw_pkg::ST_HOLD;
        end
      end
      usfw_pkg::ST_HOLD: begin
        // stalls here while the fifo is full; edges meanwhile are lost
        push = 1'b1;
        if (fifo_in_ready) begin
          complete     = 1'b1;
          next_state   = usfw_pkg::ST_IDLE;
          next_session = 1'b0;
        end
      end
      default: begin
        next_state = usfw_pkg::ST_IDLE;
      end
    endcase
    // wake beats a sleep request in the same cycle
    if ((start_det && ctrl.start_irq_en) || (complete && session)) begin // R6 R7
      next_awake = 1'b1;
    end else if (SLEEP_REQ_I) begin
      next_awake = 1'b0;
    end else begin
      next_awake = awake;
    end
    next_osc       = next_awake || next_session; // R2
    next_start_irq = start_det && ctrl.start_irq_en; // R6
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_sync) begin
    if (!rst_sync) begin
      state               <= usfw_pkg::ST_IDLE;
      div_cnt             <= '0;
      os_cnt              <= '0;
      bit_cnt             <= 4'h0;
      shift               <= '0;
      ferr                <= 1'b0;
      session             <= 1'b0;
      awake               <= 1'b1;
      OSC_ENABLE_O        <= 1'b1;
      SERIAL_CLK_ENABLE_O <= 1'b1;
      RX_START_IRQ_O      <= 1'b0;
      RX_COMPLETE_IRQ_O   <= 1'b0;
    end else begin
      state               <= next_state;
      div_cnt             <= next_div_cnt;
      os_cnt              <= next_os_cnt;
      bit_cnt             <= next_bit_cnt;
      shift               <= next_shift;
      ferr                <= next_ferr;
      session             <= next_session;
      awake               <= next_awake;
      OSC_ENABLE_O        <= next_osc;
      SERIAL_CLK_ENABLE_O <= next_osc;
      RX_START_IRQ_O      <= next_start_irq;
      RX_COMPLETE_IRQ_O   <= complete;
    end
  end

  assign SYS_CLK_ENABLE_O = awake;

  // --------------------------------------------------------------
  // receive fifo
  // --------------------------------------------------------------
  usfw_fifo #(
    .WIDTH (DATA_BITS + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (rst_sync),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({ferr, shift}),
    .out_valid_o (RX_VALID_O),
    .out_ready_i (RX_READY_I),
    .out_data_o  ({RX_FRAME_ERR_O, RX_DATA_O})
  );

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!rst_sync);

  sequence s_edge_taken;
    state == usfw_pkg::ST_IDLE && fall && (awake || ctrl.sfd_en);
  endsequence

  sequence s_asleep_edge;
    state == usfw_pkg::ST_IDLE && fall && !awake && ctrl.sfd_en;
  endsequence

  a_wake_powers_osc: assert property (s_asleep_edge |=> OSC_ENABLE_O && SERIAL_CLK_ENABLE_O && session) // R2
    else $error("start edge did not power oscillator and serial clock");

  a_sfd_off_quiet: assert property (state == usfw_pkg::ST_IDLE && !awake && !ctrl.sfd_en
                                    |=> state == usfw_pkg::ST_IDLE && !session && !SYS_CLK_ENABLE_O) // R5
    else $error("wakeup with start detection disabled");

  a_start_irq_now: assert property (s_edge_taken ##0 ctrl.start_irq_en
                                    |=> RX_START_IRQ_O && SYS_CLK_ENABLE_O ##1 !RX_START_IRQ_O) // R6
    else $error("start interrupt not raised at once");

  a_clocks_held: assert property (session && !awake && !ctrl.start_irq_en && !complete
                                  |=> !SYS_CLK_ENABLE_O && OSC_ENABLE_O == session
                                      && SERIAL_CLK_ENABLE_O == session) // R7
    else $error("system clocks ran before receive complete");

  a_complete_wakes: assert property (complete && session |=> RX_COMPLETE_IRQ_O && SYS_CLK_ENABLE_O) // R1
    else $error("receive complete did not wake the core");

  a_sync_start: assert property (ctrl.sync_mode && state == usfw_pkg::ST_START && xck_rise && !rx_s2
                                 |=> state == usfw_pkg::ST_DATA) // R4
    else $error("synchronous start bit not taken");

  a_edge_no_osc: assert property (s_asleep_edge ##0 !OSC_ENABLE_O |=> state == usfw_pkg::ST_START) // R13
    else $error("edge lost while oscillator was off");
endmodule
`default_nettype wire

/* File: test/usfw_tx_model.sv */
// usfw_tx_model: far serial transmitter driving the receive line and the synchronous bit clock.
// assumes: the bench calls send(); pins change on the falling edge of clk_i only.
`timescale 1ns/1ps
`default_nettype none
module usfw_tx_model (
  // clock
  input  wire logic clk_i,
  // serial pins
  output logic      line_o,
  output logic      xck_o
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  // line idles high as with a pull-up; bit clock stands low outside frames
  initial begin
    line_o = 1'b1;
    xck_o  = 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame: start, eight bits lsb first, stop
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] data, input logic stop_val, input logic sync, input int bit_cyc);
    logic [9:0] frame;
    frame = {stop_val, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      line_o = frame[i];
      repeat (bit_cyc / 2) @(negedge clk_i);
      if (sync) xck_o = 1'b1;
      repeat (bit_cyc - bit_cyc / 2 - 1) @(negedge clk_i);
      xck_o = 1'b0;
    end
    @(negedge clk_i);
    line_o = 1'b1;
    // a low stop bit needs a visible high gap before the next start edge
    repeat (2) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: test/usfw_start_frame_wake_tb.sv */
// usfw_start_frame_wake_tb: self-checking bench for the start frame wake receiver.
// assumes: usfw_tx_model stands for the far transmitter; words checked as they drain.
`timescale 1ns/1ps
`default_nettype none
module usfw_start_frame_wake_tb;
  localparam int TMO = 40000;
  // 2 us bit: the sync rate limit when woken from deep sleep
  localparam int SYNC_SLOW_CYC = 250;
  logic                            clk;
  logic                            rdy_nx;
  logic                            rst_n;
  logic                            sfd_en;
  logic                            sirq_en;
  logic                            sync;
  logic                            dbl;
  logic                            sleep_req;
  logic                            rdy;
  logic                            stall;
  logic [usfw_pkg::BAUD_DIV_W-1:0] div;
  logic                            line;
  logic                            xck;
  logic                            osc;
  logic                            sclk;
  logic                            sysclk;
  logic                            sirq;
  logic                            cirq;
  logic                            vld;
  logic                            ferr;
  logic [7:0]                      dat;
  logic [8:0]                      exp_q[$];
  int                              n_mismatch;
  int                              checked;
  int                              cyc;
  int                              n_start;
  int                              n_cmp;
  int                              seed;
  int                              b;

  usfw_start_frame_wake #(.DATA_BITS(8), .FIFO_DEPTH(16)) DUT (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .SERIAL_RX_LINE_I(line), .SERIAL_XCK_I(xck),
    .START_FRAME_DETECT_ENABLE_I(sfd_en), .RX_START_IRQ_ENABLE_I(sirq_en), .SYNC_MODE_I(sync),
    .DOUBLE_SPEED_I(dbl), .BAUD_DIV_I(div), .SLEEP_REQ_I(sleep_req), .OSC_ENABLE_O(osc),
    .SERIAL_CLK_ENABLE_O(sclk), .SYS_CLK_ENABLE_O(sysclk), .RX_START_IRQ_O(sirq),
    .RX_COMPLETE_IRQ_O(cirq), .RX_VALID_O(vld), .RX_READY_I(rdy), .RX_DATA_O(dat), .RX_FRAME_ERR_O(ferr)
  );

  usfw_tx_model m (.clk_i(clk), .line_o(line), .xck_o(xck));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [8:0] exp_word(input logic [7:0] d, input logic stop);
    return {~stop, d};
  endfunction

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // exact bit period, so baud error stays at zero
  task automatic frame(input logic [7:0] d, input logic stop, input logic keep);
    int bc;
    bc = sync ? (sleep_req ? SYNC_SLOW_CYC : 8) : (dbl ? 8 : 16) * (int'(div) + 1);
    if (keep) exp_q.push_back(exp_word(d, stop));
    m.send(d, stop, sync, bc);
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // monitor, drain side and timeout
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    cyc++;
    if (cyc >= TMO) begin
      n_mismatch++;
      results();
    end else begin
      if (rst_n && sirq) begin
        n_start++;
        chk(sysclk, 1'b1);
      end
      if (rst_n && cirq) begin
        n_cmp++;
        chk(sysclk, 1'b1);
      end
      // word and ready as they stand at the coming rising edge, where the pop happens
      rdy_nx = stall ? 1'b0 : 1'($random(seed));
      if (rst_n && vld && rdy_nx) chk({ferr, dat}, exp_q.size() ? exp_q.pop_front() : 32'hdead);
      rdy <= rdy_nx;
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hfe1e;
    rst_n = 1'b0;
    sfd_en = 1'b0;
    sirq_en = 1'b0;
    sync = 1'b0;
    dbl = 1'b0;
    sleep_req = 1'b0;
    rdy = 1'b0;
    stall = 1'b0;
    div = 12'h001;
    idle(8);
    chk({osc, sclk, sysclk, sirq, cirq, vld}, 6'h38);
    rst_n = 1'b1;
    idle(8);
    for (int k = 0; k < 8; k++) begin
      dbl = k[0];
      div = usfw_pkg::BAUD_DIV_W'(1 + k % 2);
      frame(8'($random(seed)), 1'b1, 1'b1);
    end
    frame(8'ha5, 1'b0, 1'b1);
    idle(60);
    chk(n_cmp, 9);
    chk(exp_q.size(), 0);
    $display("test awake frames done");
    sleep_req = 1'b1;
    idle(4);
    chk({osc, sclk, sysclk}, 3'h0);
    frame(8'($random(seed)), 1'b1, 1'b0);
    idle(60);
    chk({osc, vld}, 2'h0);
    chk(n_cmp, 9);
    $display("test detect off done");
    sfd_en = 1'b1;
    b = n_cmp;
    fork
      frame(8'($random(seed)), 1'b1, 1'b1);
      begin
        idle(8);
        chk({osc, sclk, sysclk}, 3'h6);
        chk(n_start, 0);
      end
    join
    idle(60);
    chk(n_cmp, b + 1);
    chk({osc, sysclk}, 2'h0);
    $display("test wake without start irq done");
    sirq_en = 1'b1;
    fork
      frame(8'($random(seed)), 1'b1, 1'b1);
      begin
        idle(8);
        chk(n_start, 1);
      end
    join
    idle(60);
    sirq_en = 1'b0;
    sync = 1'b1;
    for (int k = 0; k < 3; k++) frame(8'($random(seed)), k != 1, 1'b1);
    idle(60);
    chk(n_cmp, b + 5);
    chk(exp_q.size(), 0);
    $display("test start irq and sync done");
    sleep_req = 1'b0;
    sync = 1'b0;
    dbl = 1'b1;
    div = 12'h000;
    stall = 1'b1;
    for (int k = 0; k < 17; k++) frame(8'($random(seed)), 1'b1, 1'b1);
    idle(30);
    chk(vld, 1'b1);
    chk(exp_q.size(), usfw_pkg::FIFO_DEPTH_DEF + 1);
    stall = 1'b0;
    idle(200);
    chk(vld, 1'b0);
    chk(exp_q.size(), 0);
    $display("test fifo fill and drain done");
    results();
  end
endmodule
`default_nettype wire
